// [design/uiv_pkg.sv]
// uiv_pkg: shared constants of the usb endpoint interrupt vectoring block.
// assumes an 8-bit mcu data bus with 16-bit memory-mapped addresses.
package uiv_pkg;

  // register addresses on the mcu memory map
  localparam logic [15:0] ADDR_INTERRUPT_VECTOR = 16'hFFB2;
  localparam logic [15:0] ADDR_IN_ENDPOINT_PENDING = 16'hFFB3;
  localparam logic [15:0] ADDR_OUT_ENDPOINT_PENDING = 16'hFFB4;

  // register widths and reset values
  localparam int DATA_W = 8;
  localparam int CODE_W = 6;
  localparam int NUM_EP = 8;
  localparam logic [7:0] RESET_PENDING = 8'h00;
  localparam logic [7:0] RESET_VECTOR_REG = 8'h00;
  localparam logic [1:0] VECTOR_RSVD_BITS = 2'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // number of source slots, one per code 00h..21h
  localparam int NUM_SRC = 34;

  // vector codes
  localparam logic [5:0] VEC_OUT_EP0 = 6'h00;
  localparam logic [5:0] VEC_IN_EP0 = 6'h08;
  localparam logic [5:0] VEC_SETUP_OVERWRITE = 6'h10;
  localparam logic [5:0] VEC_SETUP = 6'h12;
  localparam logic [5:0] VEC_PSEUDO_SOF = 6'h13;
  localparam logic [5:0] VEC_SOF = 6'h14;
  localparam logic [5:0] VEC_RESUME = 6'h15;
  localparam logic [5:0] VEC_SUSPEND = 6'h16;
  localparam logic [5:0] VEC_FUNC_RESET = 6'h17;
  localparam logic [5:0] VEC_CPORT_RX_FULL = 6'h18;
  localparam logic [5:0] VEC_CPORT_TX_EMPTY = 6'h19;
  localparam logic [5:0] VEC_I2C_RX_FULL = 6'h1C;
  localparam logic [5:0] VEC_I2C_TX_EMPTY = 6'h1D;
  localparam logic [5:0] VEC_EXTERNAL = 6'h1F;
  localparam logic [5:0] VEC_DMA0 = 6'h20;
  localparam logic [5:0] VEC_DMA1 = 6'h21;
  localparam logic [5:0] VEC_NONE = 6'h24;
  // highest code scanned in the plain descending part of the order
  localparam logic [5:0] VEC_SCAN_TOP = 6'h1D;

endpackage

// [design/uiv_pick.sv]
// uiv_pick: fixed-priority choice of the code to present from the pending slots.
// assumes slot index equals vector code; reserved slots are held at zero by the caller.
module uiv_pick (
  input wire logic [uiv_pkg::NUM_SRC-1:0] pending_i,
  output logic [5:0] code_o
);

  // priority walk: endpoint zero first, then external, dma, then descending codes
  function automatic logic [5:0] pick_code(input logic [uiv_pkg::NUM_SRC-1:0] p);
    logic [5:0] c;
    c = uiv_pkg::VEC_NONE;
    for (int i = 1; i <= int'(uiv_pkg::VEC_SCAN_TOP); i++) begin
      if (p[i]) begin
        c = 6'(i); // higher codes overwrite lower ones
      end
    end
    if (p[uiv_pkg::VEC_DMA0]) begin
      c = uiv_pkg::VEC_DMA0;
    end
    if (p[uiv_pkg::VEC_DMA1]) begin
      c = uiv_pkg::VEC_DMA1;
    end
    if (p[uiv_pkg::VEC_EXTERNAL]) begin
      c = uiv_pkg::VEC_EXTERNAL;
    end
    if (p[uiv_pkg::VEC_OUT_EP0]) begin
      c = uiv_pkg::VEC_OUT_EP0;
    end
    if (p[uiv_pkg::VEC_IN_EP0]) begin
      c = uiv_pkg::VEC_IN_EP0;
    end
    return c;
  endfunction

  // no slot pending gives the idle code
  always_comb begin
    code_o = pick_code(pending_i);
  end

endmodule

// [design/uiv_top.sv]
// uiv_top: interrupt aggregation and vectoring for the usb streaming controller.
// assumes one-cycle event pulses from the source blocks on mclk_i and an
// asynchronous external interrupt pin; register access by a simple mcu bus.
module uiv_top #(
  parameter int NUM_EP = uiv_pkg::NUM_EP
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  // mcu register access
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic mcu_interrupt_request_o,
  // usb buffer manager completions and endpoint type
  input wire logic [NUM_EP-1:0] out_ep_done_i,
  input wire logic [NUM_EP-1:0] out_ep_iso_i,
  input wire logic [NUM_EP-1:0] in_ep_done_i,
  input wire logic [NUM_EP-1:0] in_ep_iso_i,
  // usb function events
  input wire logic setup_overwrite_i,
  input wire logic setup_i,
  input wire logic pseudo_sof_i,
  input wire logic sof_i,
  input wire logic resume_i,
  input wire logic suspend_i,
  input wire logic func_reset_i,
  // codec port, serial bus and dma events
  input wire logic cport_rx_full_i,
  input wire logic cport_tx_empty_i,
  input wire logic i2c_rx_full_i,
  input wire logic i2c_tx_empty_i,
  input wire logic dma0_i,
  input wire logic dma1_i,
  // external interrupt pin, asynchronous
  input wire logic ext_int_i
);

  logic [2:0] ext_sync;
  logic ext_level;
  logic ext_rise;
  logic [uiv_pkg::NUM_SRC-1:0] src_set;
  logic [uiv_pkg::NUM_SRC-1:0] pending;
  logic [uiv_pkg::NUM_SRC-1:0] next_pending;
  logic [5:0] vector_code;
  logic [5:0] next_code;
  logic vec_wr;
  logic vec_hold;

  // external pin: three stages, only stages two and three are compared
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_int_i};
    end
  end

  // settled level follows once the two late stages agree
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_level <= 1'b0;
    end else if (ext_sync[1] == ext_sync[2]) begin
      ext_level <= ext_sync[2];
    end
  end

  // a settled rising edge latches the external source
  assign ext_rise = ext_sync[1] && ext_sync[2] && !ext_level;

  // gather one set strobe per code slot; reserved slots stay zero
  always_comb begin
    src_set = '0;
    for (int i = 0; i < NUM_EP; i++) begin
      src_set[int'(uiv_pkg::VEC_OUT_EP0) + i] = out_ep_done_i[i] && !out_ep_iso_i[i];
      src_set[int'(uiv_pkg::VEC_IN_EP0) + i] = in_ep_done_i[i] && !in_ep_iso_i[i];
    end
    src_set[uiv_pkg::VEC_SETUP_OVERWRITE] = setup_overwrite_i;
    src_set[uiv_pkg::VEC_SETUP] = setup_i;
    src_set[uiv_pkg::VEC_PSEUDO_SOF] = pseudo_sof_i;
    src_set[uiv_pkg::VEC_SOF] = sof_i;
    src_set[uiv_pkg::VEC_RESUME] = resume_i;
    src_set[uiv_pkg::VEC_SUSPEND] = suspend_i;
    src_set[uiv_pkg::VEC_FUNC_RESET] = func_reset_i;
    src_set[uiv_pkg::VEC_CPORT_RX_FULL] = cport_rx_full_i;
    src_set[uiv_pkg::VEC_CPORT_TX_EMPTY] = cport_tx_empty_i;
    src_set[uiv_pkg::VEC_I2C_RX_FULL] = i2c_rx_full_i;
    src_set[uiv_pkg::VEC_I2C_TX_EMPTY] = i2c_tx_empty_i;
    src_set[uiv_pkg::VEC_EXTERNAL] = ext_rise;
    src_set[uiv_pkg::VEC_DMA0] = dma0_i;
    src_set[uiv_pkg::VEC_DMA1] = dma1_i;
  end

  // any write to the vector address is an acknowledge, data ignored
  assign vec_wr = wr_i && (addr_i == uiv_pkg::ADDR_INTERRUPT_VECTOR);

  // clear the presented slot on acknowledge; a same-cycle set wins
  always_comb begin
    next_pending = pending;
    if (vec_wr && vector_code != uiv_pkg::VEC_NONE) begin
      next_pending[vector_code] = 1'b0;
    end
    next_pending = next_pending | src_set;
  end

  // pending slots; serial bus status bits live in their own block, untouched
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  uiv_pick u_pick (
    .pending_i(next_pending),
    .code_o(next_code)
  );

  // vector stays put while serviced so the ack hits the code software read
  assign vec_hold = (vector_code != uiv_pkg::VEC_NONE) && !vec_wr;

  // vector register: reload when idle or on acknowledge
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vector_code <= uiv_pkg::VEC_NONE;
    end else if (!vec_hold) begin
      vector_code <= next_code;
    end
  end

  // request follows the presented vector, one cycle after a set
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mcu_interrupt_request_o <= 1'b0;
    end else begin
      mcu_interrupt_request_o <= (vec_hold ? vector_code : next_code) != uiv_pkg::VEC_NONE;
    end
  end

  // read data registered; pending registers accept no writes
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= uiv_pkg::READ_UNMAPPED;
    end else if (rd_i) begin
      case (addr_i)
        uiv_pkg::ADDR_INTERRUPT_VECTOR:
          rdata_o <= {uiv_pkg::VECTOR_RSVD_BITS, vector_code};
        uiv_pkg::ADDR_IN_ENDPOINT_PENDING:
          rdata_o <= pending[int'(uiv_pkg::VEC_IN_EP0) +: 8];
        uiv_pkg::ADDR_OUT_ENDPOINT_PENDING:
          rdata_o <= pending[int'(uiv_pkg::VEC_OUT_EP0) +: 8];
        default:
          rdata_o <= uiv_pkg::READ_UNMAPPED;
      endcase
    end
  end

endmodule

// [tb/uiv_checker.sv]
// uiv_checker: port-level assertions for uiv_top.
// assumes one clock domain and the registered read path of the mcu bus.
module uiv_checker #(
  parameter int NUM_EP = 8
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic mcu_interrupt_request_o,
  input wire logic [NUM_EP-1:0] out_ep_done_i,
  input wire logic [NUM_EP-1:0] out_ep_iso_i,
  input wire logic [NUM_EP-1:0] in_ep_done_i,
  input wire logic [NUM_EP-1:0] in_ep_iso_i,
  input wire logic i2c_rx_full_i,
  input wire logic dma1_i,
  input wire logic ext_int_i
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // read of the vector register, answer lands one cycle later
  wire logic vec_rd = rd_i && addr_i == uiv_pkg::ADDR_INTERRUPT_VECTOR;
  a_out_ep_req: assert property (
    |(out_ep_done_i & ~out_ep_iso_i) |=> mcu_interrupt_request_o) else $error("out done no req");
  a_in_ep_req: assert property (
    |(in_ep_done_i & ~in_ep_iso_i) |=> mcu_interrupt_request_o) else $error("in done no req");
  a_src_or_req: assert property (
    i2c_rx_full_i || dma1_i |=> mcu_interrupt_request_o) else $error("event no req");
  // external pin passes a synchronizer first, so allow a few cycles
  a_ext_req: assert property (
    $rose(ext_int_i) |-> ##[1:6] mcu_interrupt_request_o) else $error("ext no req");
  a_rsvd_bits: assert property (
    vec_rd |=> rdata_o[7:6] == 2'h0) else $error("vector top bits set");
  a_vec_legal: assert property (
    vec_rd |=> rdata_o[5:0] inside {[0:16], [18:25], 28, 29, [31:33], 36})
    else $error("reserved vector code");
  a_idle_code: assert property (
    vec_rd && !mcu_interrupt_request_o |=> rdata_o == 8'h24) else $error("idle code wrong");
  a_busy_code: assert property (
    vec_rd && mcu_interrupt_request_o |=> rdata_o != 8'h24) else $error("req with idle code");
endmodule
bind uiv_top uiv_checker #(.NUM_EP(NUM_EP)) i_uiv_checker (.*);

// [tb/uiv_mcu.sv]
// uiv_mcu: behavioural mcu issuing register cycles to uiv_top.
// assumes strobes taken on the rising edge; drives on the falling edge.
module uiv_mcu (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic [15:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    addr_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // any data value acknowledges; released lines show inverted values
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge mclk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // read data is registered, sampled one full cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge mclk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    @(negedge mclk_i);
    d = rdata_i;
  endtask
endmodule

// [tb/uiv_top_test.sv]
// uiv_top_test: self-checking bench for uiv_top with random source mixes.
// assumes uiv_mcu for register cycles and the checker bound to uiv_top.
module uiv_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] addr;
  logic wr, rd, req;
  logic [7:0] wdata, rdata, d;
  logic [33:0] src = '0;
  logic [15:0] iso = '0;
  logic [31:0] seed = 32'h506D65D4;
  logic [31:0] r;
  int err_total = 0;
  int total_checks = 0;
  // slots that hold a real source, ext pin is bit 31
  localparam logic [33:0] LEGAL = 34'h3_B3FD_FFFF;
  uiv_top i_uiv_top (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr), .wr_i(wr),
    .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .mcu_interrupt_request_o(req),
    .out_ep_done_i(src[7:0]), .out_ep_iso_i(iso[7:0]), .in_ep_done_i(src[15:8]),
    .in_ep_iso_i(iso[15:8]), .setup_overwrite_i(src[16]), .setup_i(src[18]),
    .pseudo_sof_i(src[19]), .sof_i(src[20]), .resume_i(src[21]), .suspend_i(src[22]),
    .func_reset_i(src[23]), .cport_rx_full_i(src[24]), .cport_tx_empty_i(src[25]),
    .i2c_rx_full_i(src[28]), .i2c_tx_empty_i(src[29]), .dma0_i(src[32]),
    .dma1_i(src[33]), .ext_int_i(src[31]));
  uiv_mcu i_uiv_mcu (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata));
  // 250 MHz clock
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // endpoint zero first, then ext pin, then descending code
  function automatic logic [5:0] best(input logic [33:0] m);
    if (m[8]) return 6'h08;
    if (m[0]) return 6'h00;
    if (m[31]) return 6'h1F;
    for (int c = 33; c > 0; c--) if (m[c]) return 6'(c);
    return 6'h24;
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // pulse a source mix, then service it one acknowledge at a time
  task automatic run(input logic [33:0] m);
    // the pin needs three sync cycles, so it leads the pulses to land on one edge
    @(negedge mclk_i) src[31] = m[31];
    repeat (3) @(negedge mclk_i);
    src = m;
    @(negedge mclk_i) src = '0;
    m = m & ~{18'h0, iso};
    repeat (6) @(negedge mclk_i);
    i_uiv_mcu.wr_reg(uiv_pkg::ADDR_OUT_ENDPOINT_PENDING, 8'hFF);
    i_uiv_mcu.wr_reg(uiv_pkg::ADDR_IN_ENDPOINT_PENDING, 8'hFF);
    i_uiv_mcu.rd_reg(16'hFFB5, d);
    check(d, 8'h00);
    for (int i = 0; i < 40 && m != 0; i++) begin
      check(req, 1'b1);
      i_uiv_mcu.rd_reg(uiv_pkg::ADDR_OUT_ENDPOINT_PENDING, d);
      check(d, m[7:0]);
      i_uiv_mcu.rd_reg(uiv_pkg::ADDR_IN_ENDPOINT_PENDING, d);
      check(d, m[15:8]);
      i_uiv_mcu.rd_reg(uiv_pkg::ADDR_INTERRUPT_VECTOR, d);
      check(d, {2'h0, best(m)});
      m[best(m)] = 1'b0;
      i_uiv_mcu.wr_reg(uiv_pkg::ADDR_INTERRUPT_VECTOR, 8'(xs()));
    end
    // slots still expected after the bound count as a timeout
    if (m != 0) check(m, 34'h0);
    i_uiv_mcu.rd_reg(uiv_pkg::ADDR_INTERRUPT_VECTOR, d);
    check(d, 8'h24);
    check(req, 1'b0);
  endtask
  // every code alone, all at once, then random mixes with iso masks
  initial begin
    repeat (16) @(negedge mclk_i);
    resetn_i = 1'b1;
    run('0);
    for (int k = 0; k < 34; k++) if (LEGAL[k]) run(34'h1 << k);
    run(LEGAL);
    // corner: a completion in the cycle of its own acknowledge stays pending
    @(negedge mclk_i) src = 34'h2;
    @(negedge mclk_i) src = '0;
    fork
      i_uiv_mcu.wr_reg(uiv_pkg::ADDR_INTERRUPT_VECTOR, 8'h5A);
      begin
        @(negedge mclk_i) src = 34'h2;
        @(negedge mclk_i) src = '0;
      end
    join
    i_uiv_mcu.rd_reg(uiv_pkg::ADDR_OUT_ENDPOINT_PENDING, d);
    check(d, 8'h02);
    i_uiv_mcu.rd_reg(uiv_pkg::ADDR_INTERRUPT_VECTOR, d);
    check(d, 8'h01);
    i_uiv_mcu.wr_reg(uiv_pkg::ADDR_INTERRUPT_VECTOR, 8'hA5);
    run('0);
    repeat (40) begin
      r = xs();
      iso = r[31:16] & r[15:0];
      run({r[1:0], xs()} & LEGAL);
    end
    summarize;
  end
endmodule
